// ### logic/pscg_pkg.sv
// Purpose: Constants for the peripheral sleep clock gating controller
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   One bit per peripheral in each enable register
package pscg_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PSCG_OFF_GATING   = 8'h00;
   localparam logic [7:0] PSCG_OFF_RUN_EN   = 8'h04;
   localparam logic [7:0] PSCG_OFF_SLEEP_EN = 8'h08;
   localparam logic [7:0] PSCG_OFF_DEEP_EN  = 8'h0C;
   localparam logic [7:0] PSCG_OFF_READY    = 8'h10;
   localparam logic [7:0] PSCG_OFF_CLK_STAT = 8'h14;
   localparam logic [7:0] PSCG_OFF_MODE     = 8'h18;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int         PSCG_GATING_BIT   = 0;
   localparam int         PSCG_MODE_SLEEP   = 0;
   localparam int         PSCG_MODE_DEEP    = 1;
   localparam logic [31:0] PSCG_RST_ZERO    = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         PSCG_ENABLE_DELAY = 5;
   localparam int         PSCG_CNT_W        = 3;
   typedef enum logic [1:0] {PSCG_RUN, PSCG_SLEEP, PSCG_DEEP} pscg_mode_type;
endpackage

// ### logic/pscg_top.sv
// Purpose: Sleep and deep-sleep peripheral clock gating controller
// Assumes: Mode inputs come from the processor on ref_clk
// Notes:   Clock enables are level outputs per peripheral
//
// What this block does
// (RULE1) Gating off: sleep clocks equal run clocks
// (RULE2) Gating on: per-peripheral sleep settings apply
// (RULE3) Global gating is one boolean bit
// (RULE4) Deep-sleep bit clear: clock stops in deep-sleep
// (RULE5) Run-enabled peripheral resumes on deep-sleep exit
// (RULE6) Gated peripheral keeps state; no reset issued
// (RULE7) Deep-sleep bit set: clock kept in deep-sleep
// (RULE8) Gating off keeps deep-sleep bits unused
// (RULE9) Software leaves only frequency-tolerant peripherals running
// (RULE10) Separate sleep and deep-sleep enable bits
// (RULE11) Run enables reset cleared
// (RULE12) Peripheral ready five cycles after enable
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
module pscg_top
   import pscg_pkg::*;
#(
   parameter int NUM_PERIPH = 32
)
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   // Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // Processor mode
   input  wire logic                  sleep_req,
   input  wire logic                  deep_sleep_req,
   // Peripheral side
   output logic      [NUM_PERIPH-1:0] periph_clk_en,
   output logic      [NUM_PERIPH-1:0] periph_ready
);
   initial begin
      if (NUM_PERIPH < 1 || NUM_PERIPH > 32)
         $error("NUM_PERIPH must be 1 to 32");
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic                  use_sleep_gating_config;
   logic [NUM_PERIPH-1:0] run_clock_enable;
   logic [NUM_PERIPH-1:0] sleep_clock_enable;
   logic [NUM_PERIPH-1:0] deep_sleep_clock_enable;
   logic                  next_use_sleep_gating_config;
   logic [NUM_PERIPH-1:0] next_run_clock_enable;
   logic [NUM_PERIPH-1:0] next_sleep_clock_enable;
   logic [NUM_PERIPH-1:0] next_deep_sleep_clock_enable;
   logic [31:0]           next_wb_dat_o;
   logic                  next_wb_ack_o;
   logic [NUM_PERIPH-1:0] run_start;
   logic [NUM_PERIPH-1:0] ready_int;
   logic [31:0]           wmask;
   logic [31:0]           wdata;
   logic                  wr_fire;
   logic                  rd_fire;
   pscg_mode_type         mode;
   pscg_mode_type         next_mode;
   logic [NUM_PERIPH-1:0] next_clk_en;

   assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_fire = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   always_comb begin
      wdata                        = PSCG_RST_ZERO;
      next_use_sleep_gating_config = use_sleep_gating_config;
      next_run_clock_enable        = run_clock_enable;
      next_sleep_clock_enable      = sleep_clock_enable;
      next_deep_sleep_clock_enable = deep_sleep_clock_enable;
      run_start                    = '0;
      next_wb_ack_o                = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_wb_dat_o                = PSCG_RST_ZERO;
      if (wr_fire) begin
         case (wb_adr_i)
            PSCG_OFF_GATING: begin
               if (wb_sel_i[0])
                  next_use_sleep_gating_config = wb_dat_i[PSCG_GATING_BIT]; // RULE3
            end
            PSCG_OFF_RUN_EN: begin
               wdata = merge(32'(run_clock_enable), wb_dat_i, wmask);
               next_run_clock_enable = wdata[NUM_PERIPH-1:0];
               run_start = next_run_clock_enable & ~run_clock_enable; // RULE12
            end
            PSCG_OFF_SLEEP_EN: begin
               wdata = merge(32'(sleep_clock_enable), wb_dat_i, wmask);
               next_sleep_clock_enable = wdata[NUM_PERIPH-1:0]; // RULE10
            end
            PSCG_OFF_DEEP_EN: begin
               wdata = merge(32'(deep_sleep_clock_enable), wb_dat_i, wmask);
               next_deep_sleep_clock_enable = wdata[NUM_PERIPH-1:0]; // RULE10
            end
            default: begin
               wdata = PSCG_RST_ZERO;
            end
         endcase
      end
      if (rd_fire) begin
         case (wb_adr_i)
            PSCG_OFF_GATING:   next_wb_dat_o = 32'(use_sleep_gating_config);
            PSCG_OFF_RUN_EN:   next_wb_dat_o = 32'(run_clock_enable);
            PSCG_OFF_SLEEP_EN: next_wb_dat_o = 32'(sleep_clock_enable);
            PSCG_OFF_DEEP_EN:  next_wb_dat_o = 32'(deep_sleep_clock_enable);
            PSCG_OFF_READY:    next_wb_dat_o = 32'(ready_int);
            PSCG_OFF_CLK_STAT: next_wb_dat_o = 32'(periph_clk_en);
            PSCG_OFF_MODE: begin
               next_wb_dat_o = PSCG_RST_ZERO;
               next_wb_dat_o[PSCG_MODE_SLEEP] = (mode == PSCG_SLEEP);
               next_wb_dat_o[PSCG_MODE_DEEP]  = (mode == PSCG_DEEP);
            end
            default:           next_wb_dat_o = PSCG_RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         use_sleep_gating_config <= 1'b0;
         run_clock_enable        <= '0; // RULE11
         sleep_clock_enable      <= '0;
         deep_sleep_clock_enable <= '0;
         wb_ack_o                <= 1'b0;
         wb_dat_o                <= PSCG_RST_ZERO;
      end else begin
         use_sleep_gating_config <= next_use_sleep_gating_config;
         run_clock_enable        <= next_run_clock_enable;
         sleep_clock_enable      <= next_sleep_clock_enable;
         deep_sleep_clock_enable <= next_deep_sleep_clock_enable; // RULE8
         wb_ack_o                <= next_wb_ack_o;
         wb_dat_o                <= next_wb_dat_o;
      end
   end

   // ----------------------------------------------------------------
   // Processor mode tracking and clock enables
   // ----------------------------------------------------------------
   always_comb begin
      case (mode)
         PSCG_RUN: begin
            if (deep_sleep_req)
               next_mode = PSCG_DEEP;
            else if (sleep_req)
               next_mode = PSCG_SLEEP;
            else
               next_mode = PSCG_RUN;
         end
         PSCG_SLEEP: begin
            if (deep_sleep_req)
               next_mode = PSCG_DEEP;
            else if (sleep_req)
               next_mode = PSCG_SLEEP;
            else
               next_mode = PSCG_RUN;
         end
         PSCG_DEEP: begin
            if (deep_sleep_req)
               next_mode = PSCG_DEEP;
            else if (sleep_req)
               next_mode = PSCG_SLEEP;
            else
               next_mode = PSCG_RUN; // RULE5
         end
         default: next_mode = PSCG_RUN;
      endcase
   end

   // Clocks only gated, never reset, so peripheral state is kept
   always_comb begin
      next_clk_en = run_clock_enable; // RULE1 RULE6
      if (use_sleep_gating_config) begin
         case (next_mode)
            PSCG_SLEEP: next_clk_en = run_clock_enable & sleep_clock_enable; // RULE2 RULE10
            PSCG_DEEP:  next_clk_en = run_clock_enable & deep_sleep_clock_enable; // RULE4 RULE7
            default:    next_clk_en = run_clock_enable; // RULE5
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode          <= PSCG_RUN;
         periph_clk_en <= '0;
         periph_ready  <= '0;
      end else begin
         mode          <= next_mode;
         periph_clk_en <= next_clk_en;
         periph_ready  <= ready_int;
      end
   end

   // ----------------------------------------------------------------
   // Enable delay, one counter per peripheral
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_wake
      pscg_wake_counter u_wake (
         .ref_clk (ref_clk),
         .rst_b   (rst_b),
         .start   (run_start[i]),
         .run_en  (next_run_clock_enable[i]),
         .ready   (ready_int[i])
      ); // RULE12
   end
endmodule

// ### logic/pscg_wake_counter.sv
// Purpose: Per-peripheral enable delay counter
// Assumes: Restart on each write that turns a clear run enable on
// Notes:   ready rises the given number of cycles after start
`timescale 1ns/1ps
module pscg_wake_counter
   import pscg_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // Control
   input  wire logic start,
   input  wire logic run_en,
   // Status
   output logic      ready
);
   logic [PSCG_CNT_W-1:0] count;
   logic [PSCG_CNT_W-1:0] next_count;
   logic                  next_ready;

   always_comb begin
      next_count = count;
      next_ready = ready;
      if (!run_en) begin
         next_count = '0;
         next_ready = 1'b0;
      end else if (start) begin
         next_count = PSCG_CNT_W'(PSCG_ENABLE_DELAY - 1);
         next_ready = 1'b0;
      end else if (count != '0) begin
         next_count = count - 1'b1;
         next_ready = (count == PSCG_CNT_W'(1));
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
         ready <= 1'b0;
      end else begin
         count <= next_count;
         ready <= next_ready;
      end
   end
endmodule

// ### tb/peripheral_sleep_clock_gating_bench.sv
// Purpose: Register-level bench for the sleep clock gating controller
// Assumes: Four run-enabled peripherals exercise every mode
// Notes:   Port checks are taken on the falling edge, read data and drives on the rising
`timescale 1ns/1ps
module peripheral_sleep_clock_gating_bench;
   import pscg_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        sleep_req = 1'b0;
   logic        deep_sleep_req = 1'b0;
   logic [31:0] periph_clk_en;
   logic [31:0] periph_ready;
   int          num_errors = 0;
   int          n_tests = 0;

   always #5 ref_clk = ~ref_clk;

   pscg_top #(.NUM_PERIPH(32)) pscg_top_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_req(sleep_req),
      .deep_sleep_req(deep_sleep_req), .periph_clk_en(periph_clk_en),
      .periph_ready(periph_ready));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                            output logic [31:0] rd);
      int n;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      if (n >= 20) begin
         check("wb_ack_o", 32'h0000_0001, 32'h0000_0000);
         summarize();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] unused;
      wb_access(1'b1, adr, dat, unused);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string name);
      logic [31:0] got;
      wb_access(1'b0, adr, 32'h0000_0000, got);
      check(name, exp, got);
   endtask
   task automatic set_mode(input logic s, input logic d);
      @(posedge ref_clk);
      sleep_req      <= s;
      deep_sleep_req <= d;
      edges(3);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int a = 0; a <= 8'h1C; a += 4) rd(a[7:0], 32'h0000_0000, "reset value");
      wr(PSCG_OFF_RUN_EN, 32'h0000_000F);
      edges(3);
      check("periph_ready early", 32'h0000_0000, periph_ready);
      edges(1);
      check("periph_ready", 32'h0000_000F, periph_ready);
      wr(PSCG_OFF_SLEEP_EN, 32'h0000_0003);
      wr(PSCG_OFF_DEEP_EN, 32'h0000_0005);
      set_mode(1'b0, 1'b1);
      check("clk_en deep gating off", 32'h0000_000F, periph_clk_en);
      rd(PSCG_OFF_MODE, 32'h0000_0002, "mode");
      set_mode(1'b1, 1'b0);
      check("clk_en sleep gating off", 32'h0000_000F, periph_clk_en);
      set_mode(1'b0, 1'b0);
      wr(PSCG_OFF_GATING, 32'hFFFF_FFFE);
      rd(PSCG_OFF_GATING, 32'h0000_0000, "gating upper bits");
      wr(PSCG_OFF_GATING, 32'h0000_0001);
      rd(PSCG_OFF_DEEP_EN, 32'h0000_0005, "deep enables kept");
      set_mode(1'b0, 1'b1);
      check("clk_en deep gating on", 32'h0000_0005, periph_clk_en);
      check("periph_ready in deep", 32'h0000_000F, periph_ready);
      set_mode(1'b1, 1'b1);
      check("clk_en deep wins", 32'h0000_0005, periph_clk_en);
      set_mode(1'b1, 1'b0);
      check("clk_en sleep gating on", 32'h0000_0003, periph_clk_en);
      set_mode(1'b0, 1'b0);
      check("clk_en after wake", 32'h0000_000F, periph_clk_en);
      wr(PSCG_OFF_READY, 32'h0000_0000);
      rd(PSCG_OFF_READY, 32'h0000_000F, "ready read only");
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h0000_0000, "unmapped");
      rd(PSCG_OFF_CLK_STAT, 32'h0000_000F, "clock status");
      summarize();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      check("run length", 32'h0000_0000, 32'h0000_0001);
      summarize();
   end
endmodule

// ### tb/pscg_top_properties.sv
// Purpose: Port-level checks for the sleep clock gating controller
// Assumes: Wishbone classic slave with a one-cycle registered answer
// Notes:   Attached to every pscg_top instance by bind
`timescale 1ns/1ps
module pscg_checker
   import pscg_pkg::*;
#(
   parameter int NUM_PERIPH = 32
)
(
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rst_b,
   // Wishbone slave
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [7:0]            wb_adr_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   // Mode and peripheral side
   input wire logic                  sleep_req,
   input wire logic                  deep_sleep_req,
   input wire logic [NUM_PERIPH-1:0] periph_clk_en,
   input wire logic [NUM_PERIPH-1:0] periph_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_follows_req_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   data_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   clk_en_cause_a: assert property ($changed(periph_clk_en) |->
      ($past(wb_ack_o) && $past(wb_we_i)) || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)) ||
      sleep_req != $past(sleep_req, 3) || $past(sleep_req) != $past(sleep_req, 3) ||
      deep_sleep_req != $past(deep_sleep_req, 3) ||
      $past(deep_sleep_req) != $past(deep_sleep_req, 3))
      else $error("clock enable changed without cause");
   ready_delay_a: assert property ($rose(periph_ready[0]) |->
      $past(wb_ack_o, 5) && $past(wb_we_i, 5))
      else $error("ready rose at wrong distance from enable write");
   clk_stat_read_a: assert property ((wb_ack_o && $past(wb_adr_i) == PSCG_OFF_CLK_STAT &&
      !$past(wb_we_i)) |-> wb_dat_o[NUM_PERIPH-1:0] == $past(periph_clk_en))
      else $error("clock status read differs from enables");
   ready_read_a: assert property ((wb_ack_o && $past(wb_adr_i) == PSCG_OFF_READY &&
      !$past(wb_we_i)) |-> wb_dat_o[NUM_PERIPH-1:0] == $past(periph_ready))
      else $error("ready read differs from ready outputs");
endmodule

bind pscg_top pscg_checker #(.NUM_PERIPH(NUM_PERIPH)) pscg_checker_inst (
   .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
   .periph_clk_en(periph_clk_en), .periph_ready(periph_ready));
